// *** shared/fmb_regs.svh ***
// Register offsets, field positions, reset values and counts of the MAC byte interface
`ifndef FMB_REGS_SVH
`define FMB_REGS_SVH
// ==========================================================
// Register byte offsets (low address byte only is decoded)
`define FMB_OFS_CTRL   8'h00
`define FMB_OFS_TXD    8'h04
`define FMB_OFS_STAT   8'h08
`define FMB_OFS_RXD    8'h0C
`define FMB_OFS_MT     8'h40
// ==========================================================
// Control fields
`define FMB_CTRL_RXEN  0
`define FMB_CTRL_PCHK  1
`define FMB_CTRL_PODD  2
`define FMB_CTRL_RST   3'h0
// ==========================================================
// Status fields that software clears by writing one
`define FMB_ST_TXAB    2
`define FMB_ST_HSER    4
`define FMB_ST_PERR    5
// ==========================================================
// Match table valid bit, address length, reset filter depth
`define FMB_MT_VALID   16
`define FMB_ADDR_BYTES 3'h6
`define FMB_RST_STAGES 3
`endif

// *** shared/fmb_pkg.sv ***
// Types shared by the MAC byte interface
package fmb_pkg;
  // ==========================================================
  // Transmit transfer-type codes
  typedef enum logic [1:0] {
    TT_FILL  = 2'b00,
    TT_START = 2'b01,
    TT_DATA  = 2'b11,
    TT_END   = 2'b10
  } fmb_tx_type_e;
  // ==========================================================
  // Decoded receive transfer kinds
  typedef enum logic [2:0] {
    RK_FILL  = 3'b000,
    RK_START = 3'b001,
    RK_DATA  = 3'b010,
    RK_END   = 3'b011,
    RK_STAT  = 3'b100,
    RK_TOKEN = 3'b101,
    RK_BAD   = 3'b110
  } fmb_rx_kind_e;
endpackage : fmb_pkg

// *** core/fmb_mac_byte_if.sv ***
// Byte-wide transmit/receive interface to the media access controller, with address match
`timescale 1ns/1ns
`include "fmb_regs.svh"
module fmb_mac_byte_if #(
  parameter int RX_DEPTH   = 8,   // Receive FIFO words, power of two
  parameter int MT_ENTRIES = 4    // Match table entries
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  output logic [7:0]       tx_byte_bus,
  output logic             tx_parity_bit,
  output logic [1:0]       tx_transfer_type,
  input  wire logic        tx_accept_ready,
  input  wire logic        tx_abort_in,
  input  wire logic [7:0]  rx_byte_bus,
  input  wire logic        rx_parity_bit,
  input  wire logic [4:0]  rx_transfer_type,
  output logic             rx_abort_out,
  input  wire logic        reject_in,
  input  wire logic        byte_clock,
  input  wire logic [7:0]  phy_symbol_pair_bus,
  input  wire logic        addr_load_strobe,
  input  wire logic        short_addr_select,
  output logic             addr_match_n_out,
  output logic             addr_match_n_oe,
  output logic             handshake_error_flag
);
  localparam int AW = $clog2(RX_DEPTH);
  localparam int SW = 27;

  // ==========================================================
  // Reset filter
  logic [`FMB_RST_STAGES-1:0] rst_sh_r;  // Release shifts through all stages
  logic                       rst_n;     // Internal reset, active low

  // Assertion is immediate, release waits several clocks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_sh_r <= '0;
    end else begin
      rst_sh_r <= {rst_sh_r[`FMB_RST_STAGES-2:0], 1'b1};
    end
  end
  assign rst_n = rst_sh_r[`FMB_RST_STAGES-1];

  // ==========================================================
  // Pin synchronisers
  logic [SW-1:0] sy1_r;   // First stage, read only by the second
  logic [SW-1:0] sy2_r;   // Safe copies
  logic          bclk_d_r;
  logic          byte_rise;
  logic          rdy_s, abort_s, rxp_s, rej_s, ld_s;
  logic [4:0]    rxt_s;
  logic [7:0]    rxb_s, phy_s;

  // Every MAC-side input pin but short_addr_select crosses two flops; the core clock samples all of them
  always_ff @(posedge hclk or negedge rst_n) begin
    if (!rst_n) begin
      sy1_r    <= '0;
      sy2_r    <= '0;
      bclk_d_r <= 1'b0;
    end else begin
      sy1_r    <= {tx_accept_ready, tx_abort_in, rx_parity_bit, rx_transfer_type, rx_byte_bus,
                   reject_in, byte_clock, phy_symbol_pair_bus, addr_load_strobe};
      sy2_r    <= sy1_r;
      bclk_d_r <= sy2_r[9];
    end
  end
  assign {rdy_s, abort_s, rxp_s, rxt_s, rxb_s, rej_s} = sy2_r[SW-1:10];
  assign phy_s     = sy2_r[8:1];
  assign ld_s      = sy2_r[0];
  assign byte_rise = sy2_r[9] & ~bclk_d_r;
  // short_addr_select has no function and is never read

  // ==========================================================
  // Bus slave
  logic        ap;        // Address phase accepted
  logic        wr_pend_r; // Write data phase pending
  logic [7:0]  wr_a_r;
  logic [2:0]  ctrl_r;
  logic [31:0] rd_val;
  logic [31:0] stat;
  logic        wr_ctrl, wr_txd, wr_stat, rd_pop;

  assign ap        = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr_ctrl   = wr_pend_r && wr_a_r == `FMB_OFS_CTRL;
  assign wr_txd    = wr_pend_r && wr_a_r == `FMB_OFS_TXD;
  assign wr_stat   = wr_pend_r && wr_a_r == `FMB_OFS_STAT;

  // Address phase capture and read data; zero wait states
  always_ff @(posedge hclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_r <= 1'b0;
      wr_a_r    <= 8'h00;
      hrdata    <= 32'h0000_0000;
    end else begin
      wr_pend_r <= ap & hwrite;
      wr_a_r    <= haddr[7:0];
      if (ap && !hwrite) begin
        hrdata <= rd_val;
      end
    end
  end

  // Control register
  always_ff @(posedge hclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `FMB_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= hwdata[2:0];
    end
  end

  // ==========================================================
  // Transmit path
  fmb_pkg::fmb_tx_type_e tx_type_r;  // Type presented now
  fmb_pkg::fmb_tx_type_e hold_type_r;
  logic [7:0]            hold_byte_r;
  logic                  hold_v_r;   // One-deep hold from software
  logic                  tx_stall, tx_load, tx_ab_r;

  assign tx_stall = tx_type_r == fmb_pkg::TT_DATA && !rdy_s;
  assign tx_load  = byte_rise && !abort_s && !tx_stall && hold_v_r;

  // Software hold; a full hold drops further writes
  always_ff @(posedge hclk or negedge rst_n) begin
    if (!rst_n) begin
      hold_v_r    <= 1'b0;
      hold_byte_r <= 8'h00;
      hold_type_r <= fmb_pkg::TT_FILL;
    end else if (tx_load || (byte_rise && abort_s)) begin
      hold_v_r <= 1'b0;
    end else if (wr_txd && !hold_v_r && hwdata[9:8] != 2'b00) begin
      hold_v_r    <= 1'b1;
      hold_byte_r <= hwdata[7:0];
      hold_type_r <= fmb_pkg::fmb_tx_type_e'(hwdata[9:8]);
    end
  end

  // One byte per byte-clock edge; filler when no frame runs
  always_ff @(posedge hclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_type_r     <= fmb_pkg::TT_FILL;
      tx_byte_bus   <= 8'h00;
      tx_parity_bit <= 1'b0;
    end else if (byte_rise) begin
      if (abort_s) begin
        tx_type_r <= fmb_pkg::TT_FILL;
      end else if (tx_stall) begin
        tx_type_r <= tx_type_r;
      end else if (hold_v_r) begin
        tx_type_r     <= hold_type_r;
        tx_byte_bus   <= hold_byte_r;
        tx_parity_bit <= ^hold_byte_r ^ ctrl_r[`FMB_CTRL_PODD];
      end else if (tx_type_r == fmb_pkg::TT_END) begin
        tx_type_r <= fmb_pkg::TT_FILL;
      end
    end
  end
  assign tx_transfer_type = tx_type_r;

  // Sticky abort seen; set wins over clear
  always_ff @(posedge hclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ab_r <= 1'b0;
    end else begin
      tx_ab_r <= (tx_ab_r & ~(wr_stat & hwdata[`FMB_ST_TXAB])) |
                 (byte_rise & abort_s & (tx_type_r != fmb_pkg::TT_FILL));
    end
  end

  // ==========================================================
  // Receive decode and control
  fmb_pkg::fmb_rx_kind_e kind;
  logic        in_frame_r, rx_abort_r, hs_err_r, perr_r, flush_r, own_r;
  logic        is_start, good_data, hs_err, deny, push, full, match_r;
  logic [AW:0] cnt_r;

  // Code table; first matching line wins
  always_comb begin
    casez (rxt_s)
      5'b?0000, 5'b??100: kind = fmb_pkg::RK_FILL;
      5'b00101:           kind = fmb_pkg::RK_START;
      5'b00001:           kind = fmb_pkg::RK_DATA;
      5'b?0?11:           kind = fmb_pkg::RK_END;
      5'b???10:           kind = fmb_pkg::RK_STAT;
      5'b10???:           kind = fmb_pkg::RK_TOKEN;
      default:            kind = fmb_pkg::RK_BAD;
    endcase
  end

  assign full      = cnt_r == (AW + 1)'(RX_DEPTH);
  assign is_start  = kind == fmb_pkg::RK_START && !in_frame_r;
  assign good_data = (kind == fmb_pkg::RK_DATA || kind == fmb_pkg::RK_END) && in_frame_r &&
                     !rx_abort_r;
  assign hs_err    = byte_rise && (kind == fmb_pkg::RK_BAD ||
                     (kind == fmb_pkg::RK_START && in_frame_r) ||
                     ((kind == fmb_pkg::RK_DATA || kind == fmb_pkg::RK_END) &&
                      !in_frame_r && !rx_abort_r));
  assign deny      = !ctrl_r[`FMB_CTRL_RXEN] || full || (rej_s && match_r);
  assign push      = byte_rise && !deny && !hs_err &&
                     (is_start || good_data || kind == fmb_pkg::RK_STAT);

  // Frame tracking; abort holds until the next start code
  always_ff @(posedge hclk or negedge rst_n) begin
    if (!rst_n) begin
      in_frame_r <= 1'b0;
      rx_abort_r <= 1'b0;
    end else if (hs_err) begin
      in_frame_r <= 1'b0;
      rx_abort_r <= 1'b1;
    end else if (byte_rise) begin
      if (is_start) begin
        in_frame_r <= 1'b1;
        rx_abort_r <= deny;
      end else if (in_frame_r && deny) begin
        rx_abort_r <= 1'b1;
      end
      if (kind == fmb_pkg::RK_END || kind == fmb_pkg::RK_TOKEN) begin
        in_frame_r <= 1'b0;
      end
    end
  end
  assign rx_abort_out = rx_abort_r;

  // Sticky error flags and last flush/own-frame bits
  always_ff @(posedge hclk or negedge rst_n) begin
    if (!rst_n) begin
      hs_err_r <= 1'b0;
      perr_r   <= 1'b0;
      flush_r  <= 1'b0;
      own_r    <= 1'b0;
    end else begin
      hs_err_r <= (hs_err_r & ~(wr_stat & hwdata[`FMB_ST_HSER])) | hs_err;
      perr_r   <= (perr_r & ~(wr_stat & hwdata[`FMB_ST_PERR])) |
                  (push & ctrl_r[`FMB_CTRL_PCHK] &
                   (rxp_s != (^rxb_s ^ ctrl_r[`FMB_CTRL_PODD])));
      if (byte_rise && (kind == fmb_pkg::RK_END || kind == fmb_pkg::RK_STAT)) begin
        flush_r <= rxt_s[2];
        own_r   <= kind == fmb_pkg::RK_STAT && rxt_s[3];
      end
    end
  end
  assign handshake_error_flag = hs_err_r;

  // ==========================================================
  // Receive FIFO: {code, parity, byte}
  logic [13:0]   mem_r [RX_DEPTH];
  logic [AW-1:0] wp_r, rp_r;

  assign rd_pop = ap && !hwrite && haddr[7:0] == `FMB_OFS_RXD && cnt_r != '0;

  // Parity is regenerated so memory always holds a correct one
  always_ff @(posedge hclk) begin
    if (push) begin
      mem_r[wp_r] <= {rxt_s, ^rxb_s ^ ctrl_r[`FMB_CTRL_PODD], rxb_s};
    end
  end

  // Pointers and fill level
  always_ff @(posedge hclk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_r + AW'(push);
      rp_r  <= rp_r + AW'(rd_pop);
      cnt_r <= cnt_r + (AW + 1)'(push) - (AW + 1)'(rd_pop);
    end
  end

  // ==========================================================
  // Address match
  logic [2:0]             ms_cnt_r;
  logic [47:0]            ms_sh_r;
  logic                   cmp_r;
  logic [MT_ENTRIES-1:0]  hit;
  logic [31:0]            mt_lo [MT_ENTRIES];
  logic [16:0]            mt_hi [MT_ENTRIES];

  // Table entries and their comparators
  for (genvar g = 0; g < MT_ENTRIES; g++) begin : g_mt
    logic [31:0] lo_r;
    logic [16:0] hi_r;
    always_ff @(posedge hclk or negedge rst_n) begin
      if (!rst_n) begin
        lo_r <= 32'h0000_0000;
        hi_r <= 17'h0_0000;
      end else if (wr_pend_r && wr_a_r == 8'(`FMB_OFS_MT + 8 * g)) begin
        lo_r <= hwdata;
      end else if (wr_pend_r && wr_a_r == 8'(`FMB_OFS_MT + 8 * g + 4)) begin
        hi_r <= hwdata[16:0];
      end
    end
    assign mt_lo[g] = lo_r;
    assign mt_hi[g] = hi_r;
    assign hit[g]   = hi_r[`FMB_MT_VALID] && {hi_r[15:0], lo_r} == ms_sh_r;
  end

  // Strobe arms a six-byte capture; result holds until next strobe
  always_ff @(posedge hclk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_r <= 3'h0;
      ms_sh_r  <= 48'h0000_0000_0000;
      cmp_r    <= 1'b0;
      match_r  <= 1'b0;
    end else begin
      cmp_r <= byte_rise && !ld_s && ms_cnt_r == 3'h1;
      if (byte_rise && ld_s) begin
        ms_cnt_r <= `FMB_ADDR_BYTES;
        match_r  <= 1'b0;
      end else if (byte_rise && ms_cnt_r != 3'h0) begin
        ms_sh_r  <= {ms_sh_r[39:0], phy_s};
        ms_cnt_r <= ms_cnt_r - 3'h1;
      end
      if (cmp_r) begin
        match_r <= |hit;
      end
    end
  end
  // Open drain: only ever pulls low
  assign addr_match_n_out = 1'b0;
  assign addr_match_n_oe  = match_r;

  // ==========================================================
  // Read multiplexer
  assign stat = {22'h0, own_r, flush_r, match_r, cnt_r != '0, perr_r, hs_err_r,
                 rx_abort_r, tx_ab_r, tx_type_r != fmb_pkg::TT_FILL, hold_v_r};

  always_comb begin
    rd_val = 32'h0000_0000;
    case (haddr[7:0])
      `FMB_OFS_CTRL: rd_val = {29'h0, ctrl_r};
      `FMB_OFS_STAT: rd_val = stat;
      `FMB_OFS_RXD:  rd_val = {cnt_r != '0, 17'h0, mem_r[rp_r]};
      default:       rd_val = 32'h0000_0000;
    endcase
    for (int i = 0; i < MT_ENTRIES; i++) begin
      if (haddr[7:0] == 8'(`FMB_OFS_MT + 8 * i)) rd_val = mt_lo[i];
      if (haddr[7:0] == 8'(`FMB_OFS_MT + 8 * i + 4)) rd_val = {15'h0, mt_hi[i]};
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!rst_n);

  property p_type_steady;
    !byte_rise |=> $stable(tx_transfer_type);
  endproperty
  a_type_steady: assert property (p_type_steady) else $error("tx type moved off edge");

  property p_fill;
    byte_rise && !hold_v_r && (tx_type_r == fmb_pkg::TT_END || tx_type_r == fmb_pkg::TT_FILL)
      |=> tx_transfer_type == 2'b00;
  endproperty
  a_fill: assert property (p_fill) else $error("no filler outside frame");

  property p_tx_par;
    tx_load |=> tx_parity_bit == (^tx_byte_bus ^ $past(ctrl_r[`FMB_CTRL_PODD]));
  endproperty
  a_tx_par: assert property (p_tx_par) else $error("tx parity wrong");

  property p_stall;
    byte_rise && tx_stall && !abort_s |=> $stable(tx_byte_bus) && tx_transfer_type == 2'b11;
  endproperty
  a_stall: assert property (p_stall) else $error("data cycle not held");

  property p_tx_abort;
    byte_rise && abort_s |=> tx_transfer_type == 2'b00 && !hold_v_r;
  endproperty
  a_tx_abort: assert property (p_tx_abort) else $error("abort did not end frame");

  property p_rx_dis;
    byte_rise && is_start && !ctrl_r[`FMB_CTRL_RXEN] |=> rx_abort_out;
  endproperty
  a_rx_dis: assert property (p_rx_dis) else $error("disabled rx not aborted");

  property p_hs;
    byte_rise && kind == fmb_pkg::RK_DATA && !in_frame_r && !rx_abort_r
      |=> rx_abort_out && handshake_error_flag;
  endproperty
  a_hs: assert property (p_hs) else $error("handshake error missed");

  property p_store_par;
    push |=> mem_r[$past(wp_r)][8] == (^$past(rxb_s) ^ $past(ctrl_r[`FMB_CTRL_PODD]));
  endproperty
  a_store_par: assert property (p_store_par) else $error("stored parity wrong");

  property p_match;
    cmp_r |=> addr_match_n_oe == $past(|hit);
  endproperty
  a_match: assert property (p_match) else $error("match output wrong");

  property p_nibble;
    byte_rise && !ld_s && ms_cnt_r != 3'h0 |=> ms_sh_r[7:0] == $past(phy_s);
  endproperty
  a_nibble: assert property (p_nibble) else $error("symbol pair order wrong");

  c_tx_end: cover property (byte_rise ##1 tx_transfer_type == 2'b10);
  c_rx_abort: cover property ($rose(rx_abort_out));
  c_match: cover property ($rose(addr_match_n_oe));
  c_hs_err: cover property ($rose(handshake_error_flag));
endmodule : fmb_mac_byte_if

// *** dv/fmb_mac_model.sv ***
// Behavioural media access controller on the far side of the byte interface
`timescale 1ns/1ns
module fmb_mac_model (
  input  wire logic  hclk,
  output logic       byte_clock,
  output logic [7:0] rx_byte_bus,
  output logic       rx_parity_bit,
  output logic [4:0] rx_transfer_type,
  output logic       tx_accept_ready,
  output logic       tx_abort_in,
  output logic       reject_in,
  output logic [7:0] phy_symbol_pair_bus,
  output logic       addr_load_strobe,
  output logic       short_addr_select
);
  logic        pend_r;  // A receive cycle waits for its slot
  logic [13:0] slot_r;  // Code, byte and parity of that cycle
  // ==========================================================
  // Free-running byte clock, 40 core clocks per period, each edge 1 ns before a core edge
  initial begin
    byte_clock          = 1'b0;
    rx_byte_bus         = 8'h00;
    rx_parity_bit       = 1'b0;
    rx_transfer_type    = 5'h00;
    tx_accept_ready     = 1'b1;
    tx_abort_in         = 1'b0;
    reject_in           = 1'b0;
    phy_symbol_pair_bus = 8'h00;
    addr_load_strobe    = 1'b0;
    short_addr_select   = 1'b0;
    pend_r              = 1'b0;
    slot_r              = 14'h0000;
    #37;
    forever #80 byte_clock = ~byte_clock;
  end
  // ==========================================================
  // Receive slot: one queued cycle, otherwise filler
  always @(negedge byte_clock) begin
    @(posedge hclk);
    if (pend_r) begin
      {rx_transfer_type, rx_byte_bus, rx_parity_bit} <= slot_r;
      pend_r = 1'b0;
    end else begin
      // Filler with a changing byte, so a stale byte is never mistaken for data
      rx_transfer_type <= 5'h00;
      rx_byte_bus      <= ~rx_byte_bus;
    end
  end
  // Wait until just after the core edge following a byte clock fall
  task automatic slot_wait();
    @(negedge byte_clock);
    @(posedge hclk);
  endtask : slot_wait
  // One receive cycle, returns at the byte edge that samples it
  task automatic rx_cycle(input logic [4:0] c, input logic [7:0] b, input logic p);
    slot_r = {c, b, p};
    pend_r = 1'b1;
    wait (pend_r == 1'b0);
    @(posedge byte_clock);
  endtask : rx_cycle
  // Ready, abort, reject and short-address levels
  task automatic set_ctl(input logic rdy, input logic abt, input logic rej, input logic sh);
    slot_wait();
    tx_accept_ready   <= rdy;
    tx_abort_in       <= abt;
    reject_in         <= rej;
    short_addr_select <= sh;
  endtask : set_ctl
  // Load strobe for one byte cycle, then six symbol-pair bytes
  task automatic addr_field(input logic [47:0] a);
    slot_wait();
    addr_load_strobe <= 1'b1;
    for (int i = 5; i >= 0; i--) begin
      slot_wait();
      addr_load_strobe    <= 1'b0;
      phy_symbol_pair_bus <= a[8*i +: 8];
    end
    @(posedge byte_clock);
  endtask : addr_field
endmodule : fmb_mac_model

// *** dv/tb_top.sv ***
// Self-checking bench of the MAC byte interface
`timescale 1ns/1ns
`include "fmb_regs.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("wrong value at %0t ns: got %h expected %h", $time, got, exp); end end
module tb_top;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, tx_parity_bit;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, tx_transfer_type;
  logic [2:0]  hsize;
  logic [7:0]  tx_byte_bus, rx_byte_bus, phy_symbol_pair_bus;
  logic [4:0]  rx_transfer_type;
  logic        tx_accept_ready, tx_abort_in, rx_parity_bit, rx_abort_out, reject_in;
  logic        byte_clock, addr_load_strobe, short_addr_select, handshake_error_flag;
  logic        addr_match_n_out, addr_match_n_oe, match_line;
  logic [12:0] frame_a [4] = '{13'h05A5, 13'h013C, 13'h075A, 13'h0E81}; // Code and byte
  int          n_errors = 0;
  int          checks   = 0;
  int          cycles   = 0;
  // Open-drain match pin with its board pull-up
  assign match_line = addr_match_n_oe ? addr_match_n_out : 1'b1;
  // ==========================================================
  // Design and controller model
  fmb_mac_byte_if u_fmb_mac_byte_if (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .tx_byte_bus,
    .tx_parity_bit, .tx_transfer_type, .tx_accept_ready, .tx_abort_in, .rx_byte_bus,
    .rx_parity_bit, .rx_transfer_type, .rx_abort_out, .reject_in, .byte_clock,
    .phy_symbol_pair_bus, .addr_load_strobe, .short_addr_select, .addr_match_n_out,
    .addr_match_n_oe, .handshake_error_flag);
  fmb_mac_model u_fmb_mac_model (.hclk, .byte_clock, .rx_byte_bus, .rx_parity_bit,
    .rx_transfer_type, .tx_accept_ready, .tx_abort_in, .reject_in, .phy_symbol_pair_bus,
    .addr_load_strobe, .short_addr_select);
  // ==========================================================
  // Clock and hang guard
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cycles++;
    // Tests need well under this many cycles
    if (cycles == 20000) begin
      n_errors++;
      end_of_test();
    end
  end
  // ==========================================================
  // Bus tasks, entered just after a core edge
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    ahb(1'b0, a, 32'h0000_0000);
    `CHK(rd & m, e)
  endtask : rdchk
  // Let a byte edge and its resynchronised effect land
  task automatic settle();
    repeat (8) @(posedge hclk);
  endtask : settle
  task automatic byte_step();
    @(posedge byte_clock);
    settle();
  endtask : byte_step
  // Frame on the transmit lines: type, byte and parity
  task automatic txchk(input logic [1:0] t, input logic [7:0] b, input logic p);
    `CHK(tx_transfer_type, t)
    `CHK(tx_byte_bus, b)
    `CHK(tx_parity_bit, p)
  endtask : txchk
  task automatic end_of_test();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  // ==========================================================
  // Main sequence
  initial begin
    {hresetn, hsel, hwrite, htrans} = 5'h00;
    haddr  = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    hsize  = 3'h2;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (6) @(posedge hclk);
    // Quiet outputs after reset, control register at zero, unmapped place reads zero
    `CHK(tx_transfer_type, fmb_pkg::TT_FILL)
    `CHK({rx_abort_out, handshake_error_flag, match_line}, 3'h1)
    `CHK(hresp, 1'b0)
    rdchk(`FMB_OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
    ahb(1'b1, 8'h20, 32'hFFFF_FFFF);
    rdchk(8'h20, 32'hFFFF_FFFF, 32'h0000_0000);
    // Transmit walk: start even parity, then odd parity, ready stall, end
    ahb(1'b1, `FMB_OFS_TXD, 32'h0000_01AA);
    byte_step();
    txchk(fmb_pkg::TT_START, 8'hAA, 1'b0);
    ahb(1'b1, `FMB_OFS_CTRL, 32'h0000_0004);
    ahb(1'b1, `FMB_OFS_TXD, 32'h0000_0355);
    byte_step();
    txchk(fmb_pkg::TT_DATA, 8'h55, 1'b1);
    u_fmb_mac_model.set_ctl(1'b0, 1'b0, 1'b0, 1'b0);
    ahb(1'b1, `FMB_OFS_TXD, 32'h0000_02CC);
    byte_step();
    txchk(fmb_pkg::TT_DATA, 8'h55, 1'b1);
    u_fmb_mac_model.set_ctl(1'b1, 1'b0, 1'b0, 1'b0);
    byte_step();
    txchk(fmb_pkg::TT_END, 8'hCC, 1'b1);
    byte_step();
    `CHK(tx_transfer_type, fmb_pkg::TT_FILL)
    // Abort in mid-frame, sticky flag then cleared by writing one
    ahb(1'b1, `FMB_OFS_TXD, 32'h0000_0177);
    byte_step();
    u_fmb_mac_model.set_ctl(1'b1, 1'b1, 1'b0, 1'b0);
    byte_step();
    `CHK(tx_transfer_type, fmb_pkg::TT_FILL)
    rdchk(`FMB_OFS_STAT, 32'h0000_0004, 32'h0000_0004);
    u_fmb_mac_model.set_ctl(1'b1, 1'b0, 1'b0, 1'b0);
    ahb(1'b1, `FMB_OFS_STAT, 32'h0000_0004);
    rdchk(`FMB_OFS_STAT, 32'h0000_0004, 32'h0000_0000);
    // Receive frame, even parity checked, a bad parity on the data byte
    ahb(1'b1, `FMB_OFS_CTRL, 32'h0000_0003);
    for (int i = 0; i < 4; i++) begin
      u_fmb_mac_model.rx_cycle(frame_a[i][12:8], frame_a[i][7:0], ^frame_a[i][7:0] ^ (i == 1));
      settle();
      `CHK(rx_abort_out, 1'b0)
    end
    u_fmb_mac_model.rx_cycle(5'b10101, 8'h00, 1'b0);
    u_fmb_mac_model.rx_cycle(5'b00100, 8'h00, 1'b0);
    settle();
    rdchk(`FMB_OFS_STAT, 32'h0000_0360, 32'h0000_0360);
    for (int i = 0; i < 4; i++) begin
      rdchk(`FMB_OFS_RXD, 32'h8000_3FFF,
            {1'b1, 17'h0_0000, frame_a[i][12:8], ^frame_a[i][7:0], frame_a[i][7:0]});
    end
    // Data outside a frame: error flagged, next start resynchronises
    u_fmb_mac_model.rx_cycle(5'b00001, 8'h00, 1'b0);
    settle();
    `CHK({handshake_error_flag, rx_abort_out}, 2'h3)
    u_fmb_mac_model.rx_cycle(5'b00101, 8'h00, 1'b0);
    settle();
    `CHK(rx_abort_out, 1'b0)
    u_fmb_mac_model.rx_cycle(5'b00011, 8'h00, 1'b0);
    u_fmb_mac_model.rx_cycle(5'b00010, 8'h00, 1'b0);
    settle();
    // Odd parity: a correct bit passes the check, a wrong one passes with the check off
    ahb(1'b1, `FMB_OFS_STAT, 32'h0000_0020);
    ahb(1'b1, `FMB_OFS_CTRL, 32'h0000_0007);
    u_fmb_mac_model.rx_cycle(5'b00101, 8'h12, 1'b1);
    settle();
    ahb(1'b1, `FMB_OFS_CTRL, 32'h0000_0005);
    u_fmb_mac_model.rx_cycle(5'b00011, 8'h34, 1'b1);
    settle();
    rdchk(`FMB_OFS_STAT, 32'h0000_0020, 32'h0000_0000);
    // Address match: nibble-swapped miss, then hit with short select ignored
    ahb(1'b1, `FMB_OFS_MT, 32'h2C3D_4E5F);
    ahb(1'b1, `FMB_OFS_MT + 8'h04, 32'h0001_0A1B);
    u_fmb_mac_model.set_ctl(1'b1, 1'b0, 1'b0, 1'b1);
    u_fmb_mac_model.addr_field(48'hA0B1_C2D3_E4F5);
    settle();
    `CHK(match_line, 1'b1)
    u_fmb_mac_model.addr_field(48'h0A1B_2C3D_4E5F);
    settle();
    `CHK(match_line, 1'b0)
    // Reject during a match refuses the frame
    u_fmb_mac_model.set_ctl(1'b1, 1'b0, 1'b1, 1'b1);
    u_fmb_mac_model.rx_cycle(5'b00101, 8'h00, 1'b0);
    settle();
    `CHK(rx_abort_out, 1'b1)
    // Reception disabled refuses the frame
    // The refused frame is closed first, so the next start is legal and not an error
    u_fmb_mac_model.set_ctl(1'b1, 1'b0, 1'b0, 1'b0);
    u_fmb_mac_model.rx_cycle(5'b00011, 8'h00, 1'b0);
    settle();
    ahb(1'b1, `FMB_OFS_STAT, 32'h0000_0010);
    ahb(1'b1, `FMB_OFS_CTRL, 32'h0000_0000);
    u_fmb_mac_model.rx_cycle(5'b00101, 8'h00, 1'b0);
    settle();
    `CHK({rx_abort_out, handshake_error_flag}, 2'h2)
    end_of_test();
  end
endmodule : tb_top
